// ===== shared/eac_defs.vh
// Offsets, field positions, reset values and timing counts of the EEPROM access block.
`ifndef EAC_DEFS_VH
`define EAC_DEFS_VH

// ************************************************************
// Register byte offsets
// ************************************************************
`define EAC_OFF_CTRL      4'h0
`define EAC_OFF_DATA      4'h4
`define EAC_OFF_IRQ_STAT  4'h8
`define EAC_OFF_IRQ_MASK  4'hC

// ************************************************************
// Control and status field positions
// ************************************************************
`define EAC_BIT_PRESENT   0
`define EAC_BIT_RD_SEL    1
`define EAC_BIT_WR_SEL    2
`define EAC_BIT_CKSUM     4
`define EAC_BIT_BULK      5
`define EAC_BIT_SINGLE    6
`define EAC_OFF_LSB       8
`define EAC_OFF_MSB       12

// ************************************************************
// Interrupt status positions
// ************************************************************
`define EAC_IRQ_RELOAD    0
`define EAC_IRQ_SINGLE    1
`define EAC_IRQ_CKSUM     2
`define EAC_IRQ_CMDERR    3

// ************************************************************
// Reset values
// ************************************************************
`define EAC_RST_RD_SEL    1'b1
`define EAC_RST_WR_SEL    1'b0
`define EAC_RST_BULK      1'b1
`define EAC_RST_SINGLE    1'b0
`define EAC_RST_CKSUM     1'b0
`define EAC_RST_OFF       5'h00
`define EAC_RST_DATA      32'h00000000
`define EAC_RST_IRQ       4'h0

// ************************************************************
// Checksum target and start-up settle count
// ************************************************************
`define EAC_CKSUM_GOOD    16'h0000
`define EAC_BOOT_CYCLES   3'h3

`endif

// ===== core/eac_core.v
// EEPROM access control: command register, bulk reload, single DWORD access.
`timescale 1ns/1ns
`include "eac_defs.vh"

// Behaviour
// R1 - Status bit 0 reads one when an EEPROM is attached, else zero.
// R2 - Reads happen only with read-select plus bulk or single trigger; read-select resets to one.
// R3 - Writes happen only with write-select plus single trigger.
// R4 - Checksum mismatch after a bulk read sets bit 4; it resets to zero.
// R5 - Software may reissue the read after a checksum error.
// R6 - Software restores default control values after a checksum error.
// R7 - Bulk trigger resets to one, stays set while reloading, then self-clears.
// R8 - Bulk trigger with write-select is an error; nothing is written.
// R9 - Single trigger reads or writes one DWORD at the offset, then self-clears.
// R10 - Offset counts DWORDs; words at twice offset and twice offset plus one.
// R11 - Triggers written during an access are ignored until it completes.

module eac_core #(
	parameter RELOAD_WORDS = 64,
	parameter ADDR_W       = 8
) (
	input  wire              i_clock,
	input  wire              i_rst_n,
	input  wire [3:0]        i_address,
	input  wire              i_read,
	input  wire              i_write,
	input  wire [31:0]       i_writedata,
	input  wire [3:0]        i_byteenable,
	output reg  [31:0]       o_readdata,
	output reg               o_waitrequest,
	output reg               o_irq,
	input  wire              i_ee_present,
	output reg               o_ee_req,
	output reg               o_ee_we,
	output reg  [ADDR_W-1:0] o_ee_addr,
	output reg  [15:0]       o_ee_wdata,
	input  wire              i_ee_ack,
	input  wire [15:0]       i_ee_rdata,
	output reg               o_cfg_wr,
	output reg  [ADDR_W-1:0] o_cfg_addr,
	output reg  [15:0]       o_cfg_data
);

	// ************************************************************
	// States and constants
	// ************************************************************
	localparam [2:0] S_BOOT = 3'h0;
	localparam [2:0] S_IDLE = 3'h1;
	localparam [2:0] S_REQ  = 3'h2;
	localparam [2:0] S_REL  = 3'h3;

	localparam integer      LAST_BULK_I = RELOAD_WORDS - 1;
	localparam [ADDR_W-1:0] LAST_BULK   = LAST_BULK_I[ADDR_W-1:0];
	localparam [ADDR_W-1:0] LAST_ONE    = {{(ADDR_W-1){1'b0}}, 1'b1};
	localparam [ADDR_W-1:0] ONE         = {{(ADDR_W-1){1'b0}}, 1'b1};

	// ************************************************************
	// Storage
	// ************************************************************
	reg              rd_sel;
	reg              wr_sel;
	reg              bulk;
	reg              single;
	reg              cksum_err;
	reg [4:0]        dword_off;
	reg [31:0]       data_reg;
	reg [3:0]        irq_stat;
	reg [3:0]        irq_mask;
	reg [3:0]        ev;
	reg [2:0]        state;
	reg [2:0]        boot_cnt;
	reg [ADDR_W-1:0] cnt;
	reg [15:0]       sum;
	reg              op_bulk;
	reg              op_we;
	reg              pres_s1;
	reg              pres_s2;
	reg              ack_s1;
	reg              ack_s2;
	reg [15:0]       rdata_s1;
	reg [15:0]       rdata_s2;

	wire             busy;
	wire             take_wr;
	wire [31:0]      bmask;
	wire [31:0]      ctrl_merged;
	wire [31:0]      ctrl_value;
	wire [3:0]       stat_clr;
	wire             last_word;
	wire [15:0]      sum_next;

	// ************************************************************
	// Bus decode helpers
	// ************************************************************
	assign busy    = (state != S_IDLE);
	assign take_wr = i_write & ~o_waitrequest;
	assign bmask   = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
	                  {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
	assign ctrl_merged = (ctrl_value & ~bmask) | (i_writedata & bmask);
	assign stat_clr = (take_wr && i_address == `EAC_OFF_IRQ_STAT) ?
	                  (i_writedata[3:0] & bmask[3:0]) : 4'h0;

	assign ctrl_value = {19'h0, dword_off, 1'b0, single, bulk, cksum_err,
	                     1'b0, wr_sel, rd_sel, pres_s2}; // [R1]

	assign last_word = op_bulk ? (cnt == LAST_BULK) : (cnt == LAST_ONE);
	assign sum_next  = sum + rdata_s2;

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pres_s1 <= 1'b0;
			pres_s2 <= 1'b0;
			ack_s1  <= 1'b0;
			ack_s2  <= 1'b0;
			rdata_s1 <= 16'h0000;
			rdata_s2 <= 16'h0000;
		end else begin
			pres_s1 <= i_ee_present;
			pres_s2 <= pres_s1;
			ack_s1  <= i_ee_ack;
			ack_s2  <= ack_s1;
			// The word is steady from the rise of the answer, so it has settled here
			// by the time the synchronised answer is seen.
			rdata_s1 <= i_ee_rdata;
			rdata_s2 <= rdata_s1;
		end
	end

	// ************************************************************
	// Bus answer
	// ************************************************************
	// Every access is answered one cycle after it appears, so the
	// master never waits longer than a single stall.
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_waitrequest <= 1'b1;
			o_readdata    <= 32'h00000000;
			o_irq         <= 1'b0;
		end else begin
			o_waitrequest <= ~((i_read | i_write) & o_waitrequest);
			o_irq         <= |(irq_stat & irq_mask);
			if (i_read && o_waitrequest) begin
				case (i_address)
					`EAC_OFF_CTRL:     o_readdata <= ctrl_value;
					`EAC_OFF_DATA:     o_readdata <= data_reg;
					`EAC_OFF_IRQ_STAT: o_readdata <= {28'h0, irq_stat};
					`EAC_OFF_IRQ_MASK: o_readdata <= {28'h0, irq_mask};
					default:           o_readdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ************************************************************
	// Registers and access sequencer
	// ************************************************************
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_sel     <= `EAC_RST_RD_SEL; // [R2]
			wr_sel     <= `EAC_RST_WR_SEL;
			bulk       <= `EAC_RST_BULK; // [R7]
			single     <= `EAC_RST_SINGLE;
			cksum_err  <= `EAC_RST_CKSUM; // [R4]
			dword_off  <= `EAC_RST_OFF;
			data_reg   <= `EAC_RST_DATA;
			irq_stat   <= `EAC_RST_IRQ;
			irq_mask   <= `EAC_RST_IRQ;
			ev         <= 4'h0;
			state      <= S_BOOT;
			boot_cnt   <= 3'h0;
			cnt        <= {ADDR_W{1'b0}};
			sum        <= 16'h0000;
			op_bulk    <= 1'b0;
			op_we      <= 1'b0;
			o_ee_req   <= 1'b0;
			o_ee_we    <= 1'b0;
			o_ee_addr  <= {ADDR_W{1'b0}};
			o_ee_wdata <= 16'h0000;
			o_cfg_wr   <= 1'b0;
			o_cfg_addr <= {ADDR_W{1'b0}};
			o_cfg_data <= 16'h0000;
		end else begin
			ev       <= 4'h0;
			o_cfg_wr <= 1'b0;
			// A new event wins over a clear in the same cycle.
			irq_stat <= (irq_stat & ~stat_clr) | ev;

			if (take_wr) begin
				case (i_address)
					`EAC_OFF_CTRL: begin
						if (bmask[`EAC_BIT_CKSUM] && i_writedata[`EAC_BIT_CKSUM])
							cksum_err <= 1'b0;
						if (!busy) begin // [R11]
							rd_sel    <= ctrl_merged[`EAC_BIT_RD_SEL];
							wr_sel    <= ctrl_merged[`EAC_BIT_WR_SEL];
							bulk      <= ctrl_merged[`EAC_BIT_BULK];
							single    <= ctrl_merged[`EAC_BIT_SINGLE];
							dword_off <= ctrl_merged[`EAC_OFF_MSB:`EAC_OFF_LSB];
						end
					end
					`EAC_OFF_DATA: begin
						if (!busy)
							data_reg <= (data_reg & ~bmask) | (i_writedata & bmask);
					end
					`EAC_OFF_IRQ_MASK: begin
						irq_mask <= (irq_mask & ~bmask[3:0]) | (i_writedata[3:0] & bmask[3:0]);
					end
					default: begin
					end
				endcase
			end

			case (state)
				S_BOOT: begin
					// Holds the reset reload back until the presence pin has
					// passed its synchroniser.
					boot_cnt <= boot_cnt + 3'h1;
					if (boot_cnt == `EAC_BOOT_CYCLES)
						state <= S_IDLE;
				end
				S_IDLE: begin
					if (bulk) begin
						if (wr_sel || !rd_sel) begin // [R8] [R2]
							bulk <= 1'b0;
							ev[`EAC_IRQ_CMDERR] <= 1'b1;
						end else if (!pres_s2) begin
							bulk <= 1'b0;
							ev[`EAC_IRQ_RELOAD] <= 1'b1;
						end else begin // [R7]
							op_bulk   <= 1'b1;
							op_we     <= 1'b0;
							cnt       <= {ADDR_W{1'b0}};
							sum       <= 16'h0000;
							o_ee_we   <= 1'b0;
							o_ee_addr <= {ADDR_W{1'b0}};
							o_ee_req  <= 1'b1;
							state     <= S_REQ;
						end
					end else if (single) begin
						if (rd_sel == wr_sel) begin // [R2] [R3]
							single <= 1'b0;
							ev[`EAC_IRQ_CMDERR] <= 1'b1;
						end else if (!pres_s2) begin
							single <= 1'b0;
							ev[`EAC_IRQ_SINGLE] <= 1'b1;
						end else begin // [R9] [R10]
							op_bulk    <= 1'b0;
							op_we      <= wr_sel;
							cnt        <= {ADDR_W{1'b0}};
							o_ee_we    <= wr_sel;
							o_ee_addr  <= {{(ADDR_W-6){1'b0}}, dword_off, 1'b0};
							o_ee_wdata <= data_reg[15:0];
							o_ee_req   <= 1'b1;
							state      <= S_REQ;
						end
					end
				end
				S_REQ: begin
					if (ack_s2) begin
						o_ee_req <= 1'b0;
						if (op_bulk) begin
							o_cfg_wr   <= 1'b1;
							o_cfg_addr <= cnt;
							o_cfg_data <= rdata_s2;
							sum        <= sum_next;
						end else if (!op_we) begin // [R10]
							if (cnt == {ADDR_W{1'b0}})
								data_reg[15:0] <= rdata_s2;
							else
								data_reg[31:16] <= rdata_s2;
						end
						state <= S_REL;
					end
				end
				S_REL: begin
					if (!ack_s2) begin
						if (last_word) begin
							state <= S_IDLE;
							if (op_bulk) begin
								bulk <= 1'b0; // [R7]
								ev[`EAC_IRQ_RELOAD] <= 1'b1;
								if (sum != `EAC_CKSUM_GOOD) begin
									cksum_err <= 1'b1; // [R4]
									ev[`EAC_IRQ_CKSUM] <= 1'b1;
								end
							end else begin
								single <= 1'b0; // [R9]
								ev[`EAC_IRQ_SINGLE] <= 1'b1;
							end
						end else begin
							cnt        <= cnt + ONE;
							o_ee_addr  <= o_ee_addr + ONE;
							o_ee_wdata <= data_reg[31:16];
							o_ee_req   <= 1'b1;
							state      <= S_REQ;
						end
					end
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

endmodule

// ===== tb/eac_ee_model.sv
// EEPROM partner model answering the word handshake.
`timescale 1ns/1ns
module eac_ee_model (
	input  wire        i_clock,
	input  wire        i_req,
	input  wire        i_we,
	input  wire [7:0]  i_addr,
	input  wire [15:0] i_wdata,
	output reg         o_ack,
	output reg  [15:0] o_rdata
);
	reg [15:0] mem [0:255];
	integer    slow = 0;
	integer    cnt = 0;
	initial o_ack = 1'b0;
	initial o_rdata = 16'h5A5A;
	// An unanswered data line toggles, so a stale word is never mistaken for data.
	always @(posedge i_clock) begin
		if (i_req && !o_ack) begin
			cnt <= cnt + 1;
			o_rdata <= ~o_rdata;
			if (cnt >= slow) begin
				if (i_we) mem[i_addr] <= i_wdata;
				o_rdata <= i_we ? ~o_rdata : mem[i_addr];
				o_ack <= 1'b1;
				cnt <= 0;
			end
		end else if (!i_req) begin
			o_ack <= 1'b0;
			o_rdata <= ~o_rdata;
		end
	end
endmodule

// ===== tb/eac_core_chk.sv
// Checker for the bus answer and the EEPROM link of the access block.
`timescale 1ns/1ns
module eac_core_chk #(
	parameter ADDR_W = 8
) (
	input wire              i_clock,
	input wire              i_rst_n,
	input wire              i_read,
	input wire              i_write,
	input wire              o_waitrequest,
	input wire              i_ee_present,
	input wire              o_ee_req,
	input wire              o_ee_we,
	input wire [ADDR_W-1:0] o_ee_addr,
	input wire              i_ee_ack,
	input wire [15:0]       i_ee_rdata,
	input wire              o_cfg_wr,
	input wire [15:0]       o_cfg_data
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	a_wait_one: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
		else $error("bus request not answered after one wait");
	a_wait_once: assert property (!o_waitrequest |=> o_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_req_present: assert property ($rose(o_ee_req) |-> i_ee_present)
		else $error("EEPROM request without an EEPROM");
	a_req_held: assert property (o_ee_req && !i_ee_ack |=> o_ee_req && $stable(o_ee_addr))
		else $error("request dropped or moved before answer");
	a_ack_drop: assert property ($rose(i_ee_ack) |-> ##[1:4] !o_ee_req)
		else $error("request not dropped after answer");
	a_req_gap: assert property ($fell(i_ee_ack) |-> !o_ee_req [*3])
		else $error("next word requested too early");
	a_cfg_word: assert property (o_cfg_wr |-> $fell(o_ee_req) && o_cfg_data == $past(i_ee_rdata))
		else $error("reloaded word wrong or mistimed");
	a_cfg_read: assert property (o_cfg_wr |-> !o_ee_we ##1 !o_cfg_wr)
		else $error("reload pulse during write or too long");
endmodule
bind eac_core eac_core_chk #(.ADDR_W(ADDR_W)) CHK (
	.i_clock(i_clock), .i_rst_n(i_rst_n), .i_read(i_read), .i_write(i_write),
	.o_waitrequest(o_waitrequest), .i_ee_present(i_ee_present), .o_ee_req(o_ee_req),
	.o_ee_we(o_ee_we), .o_ee_addr(o_ee_addr), .i_ee_ack(i_ee_ack), .i_ee_rdata(i_ee_rdata),
	.o_cfg_wr(o_cfg_wr), .o_cfg_data(o_cfg_data));

// ===== tb/eac_core_bench.sv
// Self-checking bench for the EEPROM access block.
`timescale 1ns/1ns
`include "eac_defs.vh"
module eac_core_bench;
	logic        i_clock = 1'b0;
	logic        i_rst_n = 1'b0;
	logic [3:0]  i_address = 4'h0;
	logic        i_read = 1'b0;
	logic        i_write = 1'b0;
	logic [31:0] i_writedata = 32'h0;
	logic [3:0]  i_byteenable = 4'hF;
	logic        i_ee_present = 1'b1;
	logic [31:0] v;
	wire  [31:0] o_readdata;
	wire         o_waitrequest, o_irq, o_ee_req, o_ee_we, i_ee_ack, o_cfg_wr;
	wire  [7:0]  o_ee_addr, o_cfg_addr;
	wire  [15:0] o_ee_wdata, i_ee_rdata, o_cfg_data;
	integer      err_total = 0, n_compared = 0, cyc = 0, n_cfg = 0;
	always #10 i_clock = ~i_clock;
	eac_core #(.RELOAD_WORDS(4), .ADDR_W(8)) DUT (
		.i_clock(i_clock), .i_rst_n(i_rst_n), .i_address(i_address), .i_read(i_read),
		.i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
		.o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_irq(o_irq),
		.i_ee_present(i_ee_present), .o_ee_req(o_ee_req), .o_ee_we(o_ee_we),
		.o_ee_addr(o_ee_addr), .o_ee_wdata(o_ee_wdata), .i_ee_ack(i_ee_ack),
		.i_ee_rdata(i_ee_rdata), .o_cfg_wr(o_cfg_wr), .o_cfg_addr(o_cfg_addr),
		.o_cfg_data(o_cfg_data));
	eac_ee_model EE (.i_clock(i_clock), .i_req(o_ee_req), .i_we(o_ee_we), .i_addr(o_ee_addr),
		.i_wdata(o_ee_wdata), .o_ack(i_ee_ack), .o_rdata(i_ee_rdata));
	task conclude;
		begin
			$display("compared %0d mismatches %0d", n_compared, err_total);
			if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
			else $display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("FAIL %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// The request is released on the edge it is taken, never re-raised in that step.
	task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
		begin
			i_address <= a;
			i_writedata <= d;
			i_write <= w;
			i_read <= !w;
			do @(posedge i_clock); while (o_waitrequest !== 1'b0);
			v = o_readdata;
			i_write <= 1'b0;
			i_read <= 1'b0;
			@(posedge i_clock);
		end
	endtask
	task poll(input logic [31:0] m);
		do acc(1'b0, `EAC_OFF_CTRL, 32'h0); while ((v & m) !== 32'h0);
	endtask
	always @(posedge i_clock) begin
		cyc <= cyc + 1;
		if (o_cfg_wr === 1'b1) begin
			n_cfg <= n_cfg + 1;
			chk(o_cfg_addr, n_cfg % 4);
			chk(o_cfg_data, EE.mem[n_cfg % 4]);
		end
		if (cyc == 20000) begin
			err_total = err_total + 1;
			conclude;
		end
	end
	initial begin
		for (int k = 0; k < 8; k++) EE.mem[k] = 16'h1111 * k;
		EE.mem[3] = 16'hCCCD;
		repeat (3) @(posedge i_clock);
		i_rst_n <= 1'b1;
		repeat (3) @(posedge i_clock);
		acc(1'b0, `EAC_OFF_CTRL, 32'h0);
		chk(v, 32'h23);
		acc(1'b1, `EAC_OFF_CTRL, 32'h342);
		poll(32'h20);
		chk(v, 32'h3);
		chk(n_cfg, 4);
		acc(1'b0, `EAC_OFF_IRQ_STAT, 32'h0);
		chk(v, 32'h1);
		acc(1'b1, `EAC_OFF_IRQ_STAT, 32'hF);
		acc(1'b1, `EAC_OFF_IRQ_MASK, 32'h2);
		EE.slow = 4;
		acc(1'b1, `EAC_OFF_CTRL, 32'h342);
		acc(1'b1, `EAC_OFF_CTRL, 32'h1F44);
		poll(32'h40);
		chk(v, 32'h303);
		acc(1'b0, `EAC_OFF_DATA, 32'h0);
		chk(v, 32'h77776666);
		chk(o_irq, 1);
		acc(1'b1, `EAC_OFF_IRQ_STAT, 32'h2);
		repeat (2) @(posedge i_clock);
		chk(o_irq, 0);
		EE.slow = 0;
		acc(1'b1, `EAC_OFF_DATA, 32'hCAFEBEEF);
		acc(1'b1, `EAC_OFF_CTRL, 32'h1F44);
		poll(32'h40);
		chk(v, 32'h1F05);
		chk({EE.mem[63], EE.mem[62]}, 32'hCAFEBEEF);
		acc(1'b1, `EAC_OFF_CTRL, 32'h24);
		poll(32'h20);
		chk(EE.mem[0], 0);
		acc(1'b0, `EAC_OFF_IRQ_STAT, 32'h0);
		chk(v, 32'hA);
		acc(1'b1, `EAC_OFF_IRQ_STAT, 32'hF);
		EE.mem[2] = 16'h0001;
		acc(1'b1, `EAC_OFF_CTRL, 32'h22);
		poll(32'h20);
		chk(v, 32'h13);
		chk(n_cfg, 8);
		chk(o_irq, 0);
		acc(1'b1, `EAC_OFF_IRQ_MASK, 32'h4);
		repeat (2) @(posedge i_clock);
		chk(o_irq, 1);
		EE.mem[2] = 16'h2222;
		acc(1'b1, `EAC_OFF_CTRL, 32'h32);
		poll(32'h20);
		chk(v, 32'h3);
		acc(1'b1, `EAC_OFF_CTRL, 32'h40);
		poll(32'h40);
		acc(1'b0, `EAC_OFF_DATA, 32'h0);
		chk(v, 32'hCAFEBEEF);
		i_ee_present <= 1'b0;
		repeat (4) @(posedge i_clock);
		acc(1'b1, `EAC_OFF_CTRL, 32'h342);
		poll(32'h40);
		chk(v, 32'h302);
		acc(1'b0, 4'h2, 32'h0);
		chk(v, 0);
		conclude;
	end
endmodule
